/* inc/sefh_pkg.sv */
// Constants shared by both ends of the erase and freeze command channel
package sefh_pkg;
  // ==========================================================
  // Command opcodes
  localparam logic [7:0] OP_SET_PW = 8'hf1;
  localparam logic [7:0] OP_UNLOCK = 8'hf2;
  localparam logic [7:0] OP_PREPARE = 8'hf3;
  localparam logic [7:0] OP_ERASE = 8'hf4;
  localparam logic [7:0] OP_FREEZE = 8'hf5;
  localparam logic [7:0] OP_DIS_PW = 8'hf6;
  // ==========================================================
  // Parameter sector layout
  localparam int SECT_WORDS = 256;
  localparam logic [7:0] LAST_WORD = 8'hff;
  localparam logic [7:0] PW_FIRST = 8'h01;
  localparam logic [7:0] PW_LAST = 8'h10;
  localparam int PW_BITS = 256;
  localparam int ID_BIT = 0;
  localparam int ENH_BIT = 1;
  // ==========================================================
  // Device identity, widths and reset values
  localparam logic DEV_SEL = 1'b0;
  localparam int LBA_W = 48;
  // Arbitrary value for the reported erase time
  localparam logic [15:0] ERASE_TIME_W89 = 16'h0001;
  localparam logic [PW_BITS-1:0] PW_INVALID = {PW_BITS{1'b1}};
  localparam logic LOCK_RST = 1'b0;
  localparam logic FROZEN_RST = 1'b0;
endpackage : sefh_pkg

/* inc/sefh_if.sv */
// Command, data and status wires between host controller and drive
`timescale 1ns/1ps
interface sefh_if;
  logic cmd_valid;
  logic [7:0] cmd_op;
  logic cmd_dev;
  logic wr_valid;
  logic [15:0] wr_data;
  logic crc_err;
  logic busy;
  logic drq;
  logic cmp;
  logic sts_err;
  logic err_abt;
  logic err_crc;
  modport dev (input cmd_valid, cmd_op, cmd_dev, wr_valid, wr_data, crc_err,
    output busy, drq, cmp, sts_err, err_abt, err_crc);
  modport host (output cmd_valid, cmd_op, cmd_dev, wr_valid, wr_data,
    crc_err, input busy, drq, cmp, sts_err, err_abt, err_crc);
endinterface : sefh_if

/* core/sefh_dev.sv */
// Drive end: erase-prepare, secure-erase and freeze-lock command handler
`timescale 1ns/1ps
module sefh_dev
  import sefh_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  sefh_if.dev link,
  input wire logic [PW_BITS-1:0] user_pw,
  input wire logic [PW_BITS-1:0] master_pw,
  input wire logic lock_set,
  input wire logic [LBA_W-1:0] native_max,
  input wire logic med_ready,
  input wire logic med_fail,
  output logic med_wr,
  output logic [LBA_W-1:0] med_lba,
  output logic lock_en,
  output logic frozen,
  output logic [15:0] ident_w89
);
  // ==========================================================
  // State
  typedef enum logic [1:0]
  {
    S_IDLE = 2'b00,
    S_DATA = 2'b01,
    S_CHECK = 2'b10,
    S_ERASE = 2'b11
  } sefh_state_t;

  sefh_state_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [1:0] ctl_r, ctl_nxt;
  logic [PW_BITS-1:0] pw_r, pw_nxt;
  logic crc_r, crc_nxt;
  logic prep_r, prep_nxt;
  logic frozen_r, frozen_nxt;
  logic lock_r, lock_nxt;
  logic [LBA_W-1:0] lba_r, lba_nxt;
  logic medv_r, medv_nxt;
  logic cmp_r, cmp_nxt;
  logic abt_r, abt_nxt;
  logic crcb_r, crcb_nxt;
  logic busy_r, drq_r, sts_r;
  logic [15:0] w89_r;

  // ==========================================================
  // Decode
  // Commands addressed to the other drive are ignored outright
  wire take = link.cmd_valid && (link.cmd_dev == DEV_SEL) && !busy_r;
  wire is_prep = link.cmd_op == OP_PREPARE;
  wire is_erase = link.cmd_op == OP_ERASE;
  wire is_freeze = link.cmd_op == OP_FREEZE;
  wire is_guarded = (link.cmd_op == OP_SET_PW) ||
    (link.cmd_op == OP_UNLOCK) || (link.cmd_op == OP_DIS_PW) || is_erase;
  wire word_in = (st_r == S_DATA) && link.wr_valid;
  wire is_pw_word = (cnt_r >= PW_FIRST) && (cnt_r <= PW_LAST);
  wire [7:0] pw_idx = cnt_r - PW_FIRST;
  wire use_master = ctl_r[ID_BIT];
  wire [PW_BITS-1:0] ref_pw = use_master ? master_pw : user_pw;
  wire pw_bad = (pw_r != ref_pw) || (pw_r == PW_INVALID);
  // Lock off skips the compare and refuses the user identifier; enhanced mode is refused either way
  wire chk_fail = ctl_r[ENH_BIT] ||
    (lock_r ? pw_bad : !use_master);
  wire last_lba = lba_r == native_max;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ctl_nxt = ctl_r;
    pw_nxt = pw_r;
    crc_nxt = crc_r;
    prep_nxt = prep_r;
    frozen_nxt = frozen_r;
    lock_nxt = lock_r;
    lba_nxt = lba_r;
    medv_nxt = 1'b0;
    cmp_nxt = 1'b0;
    abt_nxt = abt_r;
    crcb_nxt = crcb_r;
    if (lock_set)
    begin
      lock_nxt = 1'b1;
    end
    unique case (st_r)
      S_IDLE:
      begin
        if (take)
        begin
          abt_nxt = 1'b0;
          crcb_nxt = 1'b0;
          prep_nxt = is_prep;
          cnt_nxt = 8'h00;
          crc_nxt = 1'b0;
          if (is_guarded && frozen_r)
          begin
            cmp_nxt = 1'b1;
            abt_nxt = 1'b1;
          end
          else if (is_erase && prep_r)
          begin
            st_nxt = S_DATA;
          end
          else if (is_freeze)
          begin
            frozen_nxt = 1'b1;
            cmp_nxt = 1'b1;
          end
          else if (is_prep)
          begin
            cmp_nxt = 1'b1;
          end
          else
          begin
            // Erase without prepare, or a command not served here
            cmp_nxt = 1'b1;
            abt_nxt = 1'b1;
          end
        end
      end
      S_DATA:
      begin
        crc_nxt = crc_r | link.crc_err;
        if (word_in)
        begin
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == 8'h00)
          begin
            ctl_nxt = link.wr_data[1:0];
          end
          if (is_pw_word)
          begin
            pw_nxt[pw_idx[3:0]*16 +: 16] = link.wr_data;
          end
          if (cnt_r == LAST_WORD)
          begin
            st_nxt = S_CHECK;
          end
        end
      end
      S_CHECK:
      begin
        if (chk_fail)
        begin
          st_nxt = S_IDLE;
          cmp_nxt = 1'b1;
          abt_nxt = 1'b1;
          crcb_nxt = crc_r;
        end
        else
        begin
          st_nxt = S_ERASE;
          lba_nxt = '0;
          medv_nxt = 1'b1;
        end
      end
      S_ERASE:
      begin
        // Zero writes only, no verify pass; spare lists are not touched
        medv_nxt = 1'b1;
        if (med_ready)
        begin
          if (med_fail)
          begin
            st_nxt = S_IDLE;
            medv_nxt = 1'b0;
            cmp_nxt = 1'b1;
            abt_nxt = 1'b1;
            crcb_nxt = crc_r;
          end
          else if (last_lba)
          begin
            st_nxt = S_IDLE;
            medv_nxt = 1'b0;
            cmp_nxt = 1'b1;
            lock_nxt = 1'b0;
            crcb_nxt = crc_r;
          end
          else
          begin
            lba_nxt = lba_r + 48'h1;
          end
        end
      end
    endcase
  end

  // ==========================================================
  // Registers
  // Frozen and lock survive soft resets; power-on clears both, a completed erase also clears lock
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frozen_r <= FROZEN_RST;
      lock_r <= LOCK_RST;
    end
    else
    begin
      frozen_r <= frozen_nxt;
      lock_r <= lock_nxt;
    end
  end

  // Command machine, cleared by either reset
  always_ff @(posedge clk)
  begin
    if (rst || soft_rst)
    begin
      st_r <= S_IDLE;
      cnt_r <= 8'h00;
      ctl_r <= 2'h0;
      pw_r <= '0;
      crc_r <= 1'b0;
      prep_r <= 1'b0;
      lba_r <= '0;
      medv_r <= 1'b0;
      cmp_r <= 1'b0;
      abt_r <= 1'b0;
      crcb_r <= 1'b0;
      busy_r <= 1'b0;
      drq_r <= 1'b0;
      w89_r <= 16'h0000;
      sts_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ctl_r <= ctl_nxt;
      pw_r <= pw_nxt;
      crc_r <= crc_nxt;
      prep_r <= prep_nxt;
      lba_r <= lba_nxt;
      medv_r <= medv_nxt;
      cmp_r <= cmp_nxt;
      abt_r <= abt_nxt;
      crcb_r <= crcb_nxt;
      busy_r <= st_nxt != S_IDLE;
      drq_r <= st_nxt == S_DATA;
      w89_r <= ERASE_TIME_W89;
      // Summary bit kept in its own flop so the pin has no gate after it
      sts_r <= abt_nxt | crcb_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign link.busy = busy_r;
  assign link.drq = drq_r;
  assign link.cmp = cmp_r;
  assign link.err_abt = abt_r;
  assign link.err_crc = crcb_r;
  assign link.sts_err = sts_r;
  assign med_wr = medv_r;
  assign med_lba = lba_r;
  assign lock_en = lock_r;
  assign frozen = frozen_r;
  assign ident_w89 = w89_r;
endmodule : sefh_dev

/* core/sefh_host.sv */
// Host end: issues prepare plus erase, or freeze, over the command channel
`timescale 1ns/1ps
module sefh_host
  import sefh_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  sefh_if.host link,
  input wire logic go_erase,
  input wire logic go_freeze,
  input wire logic use_master,
  input wire logic enhanced,
  input wire logic [PW_BITS-1:0] pw,
  input wire logic inject_crc,
  output logic busy,
  output logic done,
  output logic aborted,
  output logic crc_seen
);
  // ==========================================================
  // State
  typedef enum logic [2:0]
  {
    H_IDLE = 3'b000,
    H_PREP = 3'b001,
    H_PWAIT = 3'b010,
    H_ERASE = 3'b011,
    H_DWAIT = 3'b100,
    H_DATA = 3'b101,
    H_WAIT = 3'b110
  } sefh_hstate_t;

  sefh_hstate_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [1:0] ctl_r;
  logic [PW_BITS-1:0] pw_r;
  logic cv_r, cv_nxt;
  logic [7:0] op_r, op_nxt;
  logic wv_r, wv_nxt;
  logic [15:0] wd_r, wd_nxt;
  logic crc_r, done_r, done_nxt, abt_r, abt_nxt, crcs_r, crcs_nxt;

  // ==========================================================
  // Parameter word for the current count
  wire is_pw_word = (cnt_r >= PW_FIRST) && (cnt_r <= PW_LAST);
  wire [7:0] pw_idx = cnt_r - PW_FIRST;
  wire [15:0] word_sel = (cnt_r == 8'h00) ? {14'h0000, ctl_r} :
    is_pw_word ? pw_r[pw_idx[3:0]*16 +: 16] : 16'h0000;
  wire idle = (st_r == H_IDLE) && !link.busy && !cv_r;

  // ==========================================================
  // Sequencer
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cv_nxt = 1'b0;
    op_nxt = op_r;
    wv_nxt = 1'b0;
    wd_nxt = wd_r;
    done_nxt = 1'b0;
    abt_nxt = abt_r;
    crcs_nxt = crcs_r;
    unique case (st_r)
      H_IDLE:
      begin
        if (idle && go_erase)
        begin
          st_nxt = H_PWAIT;
          cv_nxt = 1'b1;
          op_nxt = OP_PREPARE;
        end
        else if (idle && go_freeze)
        begin
          st_nxt = H_WAIT;
          cv_nxt = 1'b1;
          op_nxt = OP_FREEZE;
        end
      end
      H_PREP:
      begin
        st_nxt = H_PWAIT;
      end
      H_PWAIT:
      begin
        if (link.cmp && link.err_abt)
        begin
          st_nxt = H_IDLE;
          done_nxt = 1'b1;
          abt_nxt = 1'b1;
          crcs_nxt = link.err_crc;
        end
        else if (link.cmp)
        begin
          st_nxt = H_DWAIT;
          cv_nxt = 1'b1;
          op_nxt = OP_ERASE;
        end
      end
      H_ERASE:
      begin
        st_nxt = H_DWAIT;
      end
      H_DWAIT:
      begin
        cnt_nxt = 8'h00;
        if (link.cmp)
        begin
          st_nxt = H_IDLE;
          done_nxt = 1'b1;
          abt_nxt = link.err_abt;
          crcs_nxt = link.err_crc;
        end
        else if (link.drq && !cv_r)
        begin
          st_nxt = H_DATA;
        end
      end
      H_DATA:
      begin
        wv_nxt = 1'b1;
        wd_nxt = word_sel;
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == LAST_WORD)
        begin
          st_nxt = H_WAIT;
        end
      end
      H_WAIT:
      begin
        if (link.cmp)
        begin
          st_nxt = H_IDLE;
          done_nxt = 1'b1;
          abt_nxt = link.err_abt;
          crcs_nxt = link.err_crc;
        end
      end
      default:
      begin
        st_nxt = H_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= H_IDLE;
      cnt_r <= 8'h00;
      ctl_r <= 2'h0;
      pw_r <= '0;
      cv_r <= 1'b0;
      op_r <= 8'h00;
      wv_r <= 1'b0;
      wd_r <= 16'h0000;
      crc_r <= 1'b0;
      done_r <= 1'b0;
      abt_r <= 1'b0;
      crcs_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      if (idle && go_erase)
      begin
        ctl_r <= {enhanced, use_master};
        pw_r <= pw;
      end
      cv_r <= cv_nxt;
      op_r <= op_nxt;
      wv_r <= wv_nxt;
      wd_r <= wd_nxt;
      crc_r <= inject_crc && wv_nxt;
      done_r <= done_nxt;
      abt_r <= abt_nxt;
      crcs_r <= crcs_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign link.cmd_valid = cv_r;
  assign link.cmd_op = op_r;
  assign link.cmd_dev = DEV_SEL;
  assign link.wr_valid = wv_r;
  assign link.wr_data = wd_r;
  assign link.crc_err = crc_r;
  assign busy = st_r != H_IDLE;
  assign done = done_r;
  assign aborted = abt_r;
  assign crc_seen = crcs_r;
endmodule : sefh_host

/* tb/sefh_checker.sv */
// Assertions on the command channel between host and drive ends
`timescale 1ns/1ps
module sefh_checker
  import sefh_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic cmd_dev,
  input wire logic wr_valid,
  input wire logic [15:0] wr_data,
  input wire logic crc_err,
  input wire logic busy,
  input wire logic drq,
  input wire logic cmp,
  input wire logic sts_err,
  input wire logic err_abt,
  input wire logic err_crc
);
  // ==========================================================
  // Take decode; a strobe while busy is ignored, so it is no take
  wire take = cmd_valid && (cmd_dev == DEV_SEL) && !busy;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Channel properties
  chk_freeze_done: assert property (
    take && cmd_op == OP_FREEZE |=> cmp && !err_abt && !busy && !drq)
    else $error("freeze did not complete cleanly");
  chk_erase_answer: assert property (
    take && cmd_op == OP_ERASE |=> (busy && drq && !cmp) || (cmp && err_abt))
    else $error("erase neither asked for data nor aborted");
  chk_prep_done: assert property (
    take && cmd_op == OP_PREPARE |=> cmp && !busy && !drq)
    else $error("prepare did not complete next cycle");
  // Covers strobes for the other drive too: no take, no answer
  chk_dev_select: assert property (
    !take && !busy |=> !cmp && !busy)
    else $error("completion without a taken command");
  chk_err_sum: assert property (
    sts_err == (err_abt || err_crc))
    else $error("status error bit disagrees with error bits");
  chk_err_hold: assert property (
    !$past(take) && !cmp |-> $stable(err_abt) && $stable(err_crc))
    else $error("error bits moved between commands");
  chk_drq_busy: assert property (
    drq |-> busy)
    else $error("data request without busy");
  chk_drq_word: assert property (
    drq && !wr_valid |=> drq)
    else $error("data request dropped without a word");
  chk_busy_end: assert property (
    $fell(busy) |-> cmp)
    else $error("busy ended without completion");
endmodule : sefh_checker

/* tb/security_erase_freeze_handler_tb_top.sv */
// Bench: host and drive joined, plus a drive under direct command
`timescale 1ns/1ps
module security_erase_freeze_handler_tb_top;
  import sefh_pkg::*;
  typedef struct packed {
    logic lk, ms, en, cr, mf, ab;
    logic [1:0] pc;
  } sefh_row_t;
  // Small native maximum keeps each erase short
  localparam logic [LBA_W-1:0] NMAX = 48'h3;
  // Row bits, high to low: lk ms en cr mf ab pc[1:0]
  localparam sefh_row_t ROWS [9] = '{8'h40, 8'h04, 8'h64, 8'h80, 8'hc4,
    8'hc1, 8'h86, 8'h50, 8'h4c};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic lock_set = 1'b0;
  logic med_ready = 1'b0;
  logic med_fail = 1'b0;
  logic go_erase = 1'b0;
  logic go_freeze = 1'b0;
  logic [PW_BITS-1:0] upw = {8{32'h1234abcd}};
  logic [PW_BITS-1:0] mpw = {8{32'h0badcafe}};
  sefh_row_t r = '0;
  logic h_busy, done, aborted, crc_seen, med_wr, lock_en, frozen, frozen_b;
  logic [LBA_W-1:0] med_lba;
  logic [15:0] ident_w89;
  int err_count = 0;
  int compares = 0;
  int nw = 0;
  // Password choice per row; code 2 stores and sends the invalid value
  wire logic [PW_BITS-1:0] ustore = (r.pc == 2'h2) ? PW_INVALID : upw;
  wire logic [PW_BITS-1:0] pw_sel = (r.pc == 2'h1) ? mpw : ustore;
  sefh_if if_a ();
  sefh_if if_b ();
  always #50 clk = ~clk;
  // ==========================================================
  // Design ends
  sefh_host u_sefh_host (.clk(clk), .rst(rst), .link(if_a.host),
    .go_erase(go_erase), .go_freeze(go_freeze), .use_master(r.ms),
    .enhanced(r.en), .pw(pw_sel), .inject_crc(r.cr), .busy(h_busy),
    .done(done), .aborted(aborted), .crc_seen(crc_seen));
  sefh_dev u_sefh_dev (.clk(clk), .rst(rst), .soft_rst(soft_rst),
    .link(if_a.dev), .user_pw(ustore), .master_pw(mpw), .lock_set(lock_set),
    .native_max(NMAX), .med_ready(med_ready), .med_fail(med_fail),
    .med_wr(med_wr), .med_lba(med_lba), .lock_en(lock_en), .frozen(frozen),
    .ident_w89(ident_w89));
  sefh_dev u_sefh_dev_b (.clk(clk), .rst(rst), .soft_rst(soft_rst),
    .link(if_b.dev), .user_pw(ustore), .master_pw(mpw), .lock_set(lock_set),
    .native_max(NMAX), .med_ready(med_ready), .med_fail(med_fail),
    .med_wr(), .med_lba(), .lock_en(), .frozen(frozen_b), .ident_w89());
  sefh_checker u_sefh_checker (.clk(clk), .rst(rst),
    .cmd_valid(if_a.cmd_valid), .cmd_op(if_a.cmd_op),
    .cmd_dev(if_a.cmd_dev), .wr_valid(if_a.wr_valid),
    .wr_data(if_a.wr_data), .crc_err(if_a.crc_err), .busy(if_a.busy),
    .drq(if_a.drq), .cmp(if_a.cmp), .sts_err(if_a.sts_err),
    .err_abt(if_a.err_abt), .err_crc(if_a.err_crc));
  // ==========================================================
  // Medium stalls every other cycle; writes must walk up from zero
  always @(negedge clk) med_ready <= ~med_ready;
  always @(posedge clk)
  begin
    if (med_wr && med_ready)
    begin
      chk(med_lba, nw);
      nw++;
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    nw = 0;
    @(negedge clk);
  endtask : do_reset
  // Bounded wait for the host's completion pulse
  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 3000)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask : wait_done
  task automatic go(input logic fz);
    go_erase = !fz;
    go_freeze = fz;
    @(negedge clk);
    go_erase = 1'b0;
    go_freeze = 1'b0;
    wait_done();
  endtask : go
  // Raw command on the second channel; the completion pulse stands
  // only in the cycle right after the take, so look there
  task automatic raw(input logic [7:0] op, input logic dv, input logic ab);
    if_b.cmd_op = op;
    if_b.cmd_dev = dv;
    if_b.cmd_valid = 1'b1;
    @(negedge clk);
    chk(if_b.cmp, !dv);
    chk(if_b.err_abt, ab && !dv);
    if_b.cmd_valid = 1'b0;
    @(negedge clk);
  endtask : raw
  // ==========================================================
  // Main sequence
  initial
  begin
    logic [7:0] rej [4];
    rej = '{OP_SET_PW, OP_UNLOCK, OP_DIS_PW, OP_ERASE};
    if_b.cmd_valid = 1'b0;
    if_b.cmd_op = 8'h00;
    if_b.cmd_dev = 1'b0;
    if_b.wr_valid = 1'b0;
    if_b.wr_data = 16'h0000;
    if_b.crc_err = 1'b0;
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      med_fail = r.mf;
      do_reset();
      lock_set = r.lk;
      @(negedge clk);
      lock_set = 1'b0;
      go(1'b0);
      chk(aborted, r.ab);
      chk(nw, r.ab ? {63'h0, r.mf} : NMAX + 1);
      chk(lock_en, r.lk && r.ab);
      chk(crc_seen, r.cr);
      chk(h_busy, 1'b0);
    end
    r = '0;
    med_fail = 1'b0;
    do_reset();
    chk(ident_w89, ERASE_TIME_W89);
    go(1'b1);
    chk(frozen, 1'b1);
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
    chk(frozen, 1'b1);
    go(1'b0);
    chk(aborted, 1'b1);
    chk(nw, 0);
    do_reset();
    chk(frozen, 1'b0);
    raw(OP_FREEZE, 1'b1, 1'b0);
    chk(frozen_b, 1'b0);
    raw(OP_ERASE, 1'b0, 1'b1);
    raw(OP_PREPARE, 1'b0, 1'b0);
    raw(OP_SET_PW, 1'b0, 1'b1);
    raw(OP_ERASE, 1'b0, 1'b1);
    raw(OP_FREEZE, 1'b0, 1'b0);
    chk(frozen_b, 1'b1);
    foreach (rej[k])
    begin
      raw(OP_PREPARE, 1'b0, 1'b0);
      raw(rej[k], 1'b0, 1'b1);
    end
    tally_and_finish();
  end
endmodule : security_erase_freeze_handler_tb_top
